// ---- src/branch_unit_pkg.sv ----
package branch_unit_pkg;

	// Status word layout
	localparam int STATUS_W          = 9;
	localparam int FIRST_CHECK_POS   = 0;
	localparam int LOGIC_RESULT_POS  = 1;
	localparam int OPERAND_LEVEL_POS = 2;
	localparam int DISJUNCTION_POS   = 3;
	localparam int STICKY_RANGE_POS  = 4;
	localparam int RANGE_EXCEED_POS  = 5;
	localparam int COND_CODE0_POS    = 6;
	localparam int COND_CODE1_POS    = 7;
	localparam int BINARY_RESULT_POS = 8;
	localparam logic [STATUS_W-1:0] STATUS_RESET = 9'h000;

	// Control register layout
	localparam int CTRL_ENABLE_POS   = 0;
	localparam int CTRL_CLEAR_POS    = 1;
	localparam logic CTRL_ENABLE_RESET = 1'b1;

	// Register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_STATUS      = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL     = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_TAKEN_COUNT = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_EXEC_COUNT  = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_LAST_TARGET = 8'h10;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Jump displacement in code words, signed
	localparam int DISP_W   = 16;
	localparam int LEN_W    = 2;
	localparam int PC_W_DEF = 24;

	typedef enum logic [2:0] {
		op_logic_false,
		op_logic_true_save,
		op_logic_false_save,
		op_binres_set,
		op_binres_clear,
		op_range_error,
		op_sticky_range
	} op_t;

	typedef enum logic [2:0] {
		sel_status,
		sel_control,
		sel_taken_count,
		sel_exec_count,
		sel_last_target,
		sel_none
	} reg_sel_t;

endpackage : branch_unit_pkg

// ---- src/branch_decide.sv ----
module branch_decide
	import branch_unit_pkg::*;
(
	input  op_t                 op,
	input  wire [STATUS_W-1:0]  status_in,
	output logic                taken,
	output logic [STATUS_W-1:0] status_out
);

	// Close the logic string: the jump target starts a fresh one
	function automatic logic [STATUS_W-1:0] close_string(input logic [STATUS_W-1:0] s);
		logic [STATUS_W-1:0] r;
		r = s;
		r[DISJUNCTION_POS]   = 1'b0;
		r[OPERAND_LEVEL_POS] = 1'b1;
		r[FIRST_CHECK_POS]   = 1'b0;
		return r;
	endfunction : close_string

	logic logic_result_bit;
	assign logic_result_bit = status_in[LOGIC_RESULT_POS];

	always_comb begin
		taken      = 1'b0;
		status_out = status_in;
		case (op)
			op_logic_false: begin
				taken      = ~logic_result_bit;
				status_out = close_string(status_in);
				status_out[LOGIC_RESULT_POS] = 1'b1;
			end
			op_logic_true_save: begin
				taken      = logic_result_bit;
				status_out = close_string(status_in);
				status_out[LOGIC_RESULT_POS]  = 1'b1;
				status_out[BINARY_RESULT_POS] = logic_result_bit;
			end
			op_logic_false_save: begin
				taken      = ~logic_result_bit;
				status_out = close_string(status_in);
				status_out[LOGIC_RESULT_POS]  = 1'b1;
				status_out[BINARY_RESULT_POS] = logic_result_bit;
			end
			op_binres_set: begin
				taken      = status_in[BINARY_RESULT_POS];
				status_out = close_string(status_in);
			end
			op_binres_clear: begin
				taken      = ~status_in[BINARY_RESULT_POS];
				status_out = close_string(status_in);
			end
			op_range_error: begin
				taken = status_in[RANGE_EXCEED_POS];
			end
			op_sticky_range: begin
				taken = status_in[STICKY_RANGE_POS];
				status_out[STICKY_RANGE_POS] = 1'b0;
			end
			default: begin
				taken      = 1'b0;
				status_out = status_in;
			end
		endcase
	end

endmodule : branch_decide

// ---- src/pc_target_calc.sv ----
module pc_target_calc
	import branch_unit_pkg::*;
#(
	parameter int PC_W = PC_W_DEF
) (
	input  wire [PC_W-1:0]   pc,
	input  wire [DISP_W-1:0] disp,
	input  wire [LEN_W-1:0]  len,
	output logic [PC_W-1:0]  branch_target,
	output logic [PC_W-1:0]  seq_next
);

	logic [PC_W-1:0] disp_ext;

	// Signed word offset from the jump's own address, both directions
	assign disp_ext      = {{(PC_W-DISP_W){disp[DISP_W-1]}}, disp};
	assign branch_target = pc + disp_ext;
	// Fall-through skips the one, two or three words of this instruction
	assign seq_next      = pc + {{(PC_W-LEN_W){1'b0}}, len};

endmodule : pc_target_calc

// ---- src/conditional_branch_unit.sv ----
module conditional_branch_unit
	import branch_unit_pkg::*;
#(
	parameter int PC_W = PC_W_DEF
) (
	input  wire                 aclk,
	input  wire                 aresetn,
	input  wire [ADDR_W-1:0]    s_axi_awaddr,
	input  wire                 s_axi_awvalid,
	output logic                s_axi_awready,
	input  wire [31:0]          s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output logic                s_axi_wready,
	output logic [1:0]          s_axi_bresp,
	output logic                s_axi_bvalid,
	input  wire                 s_axi_bready,
	input  wire [ADDR_W-1:0]    s_axi_araddr,
	input  wire                 s_axi_arvalid,
	output logic                s_axi_arready,
	output logic [31:0]         s_axi_rdata,
	output logic [1:0]          s_axi_rresp,
	output logic                s_axi_rvalid,
	input  wire                 s_axi_rready,
	input  wire                 instr_valid,
	output logic                instr_ready,
	input  op_t                 instr_op,
	input  wire [PC_W-1:0]      instr_pc,
	input  wire [DISP_W-1:0]    instr_disp,
	input  wire [LEN_W-1:0]     instr_len,
	input  wire                 flags_load,
	input  wire [STATUS_W-1:0]  flags_in,
	output logic                exec_done,
	output logic                exec_taken,
	output logic                fetch_flush,
	output logic [PC_W-1:0]     pc_next,
	output logic [STATUS_W-1:0] status_word
);

	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
		case (addr)
			ADDR_STATUS:      return sel_status;
			ADDR_CONTROL:     return sel_control;
			ADDR_TAKEN_COUNT: return sel_taken_count;
			ADDR_EXEC_COUNT:  return sel_exec_count;
			ADDR_LAST_TARGET: return sel_last_target;
			default:          return sel_none;
		endcase
	endfunction : decode

	logic [ADDR_W-1:0]   aw_addr;
	logic                aw_full;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                w_full;
	logic [ADDR_W-1:0]   ar_addr;
	logic                ar_full;
	logic                write_fire;
	logic                read_fire;
	logic                next_aw_full;
	logic                next_w_full;
	logic                next_ar_full;
	reg_sel_t            wr_sel;
	reg_sel_t            rd_sel;
	logic                ctrl_enable;
	logic                clear_counts;
	logic [31:0]         taken_count;
	logic [31:0]         exec_count;
	logic [PC_W-1:0]     last_target;
	logic                instr_fire;
	logic                dec_taken;
	logic [STATUS_W-1:0] dec_status;
	logic [PC_W-1:0]     branch_target;
	logic [PC_W-1:0]     seq_next;
	logic [31:0]         read_value;
	logic                aw_take;
	logic                w_take;
	logic                ar_take;
	logic                wr_err;
	logic                rd_err;
	logic                status_write;
	logic                ctrl_write;
	logic                branch_taken;
	logic [STATUS_W-1:0] next_status;

	// Decision and status update for the instruction on offer
	branch_decide u_decide (
		.op         (instr_op),
		.status_in  (status_word),
		.taken      (dec_taken),
		.status_out (dec_status)
	);

	// Both candidate addresses are formed every cycle
	pc_target_calc #(
		.PC_W (PC_W)
	) u_target (
		.pc            (instr_pc),
		.disp          (instr_disp),
		.len           (instr_len),
		.branch_target (branch_target),
		.seq_next      (seq_next)
	);

	// Write channel: address and data taken in either order, then one response
	assign aw_take      = s_axi_awvalid & s_axi_awready;
	assign w_take       = s_axi_wvalid & s_axi_wready;
	assign write_fire   = aw_full & w_full & ~s_axi_bvalid;
	assign next_aw_full = (aw_full & ~write_fire) | aw_take;
	assign next_w_full  = (w_full & ~write_fire) | w_take;
	assign wr_sel       = decode(aw_addr);
	assign wr_err       = (wr_sel == sel_none);
	assign status_write = write_fire & (wr_sel == sel_status);
	assign ctrl_write   = write_fire & (wr_sel == sel_control) & w_strb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			s_axi_awready <= 1'b0;
		end else begin
			aw_full       <= next_aw_full;
			s_axi_awready <= ~next_aw_full;
		end
	end

	// Address is kept until its write fires
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr <= '0;
		end else if (aw_take) begin
			aw_addr <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full       <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			w_full       <= next_w_full;
			s_axi_wready <= ~next_w_full;
		end
	end

	// Data and strobes wait here for their address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_data <= '0;
			w_strb <= '0;
		end else if (w_take) begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (write_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: one read in flight, data registered with its valid
	assign ar_take      = s_axi_arvalid & s_axi_arready;
	assign read_fire    = ar_full & ~s_axi_rvalid;
	assign next_ar_full = (ar_full & ~read_fire) | ar_take;
	assign rd_sel       = decode(ar_addr);
	assign rd_err       = (rd_sel == sel_none);

	// Unmapped offsets read as zero
	always_comb begin
		read_value = '0;
		case (rd_sel)
			sel_status:      read_value[STATUS_W-1:0] = status_word;
			sel_control:     read_value[CTRL_ENABLE_POS] = ctrl_enable;
			sel_taken_count: read_value = taken_count;
			sel_exec_count:  read_value = exec_count;
			sel_last_target: read_value[PC_W-1:0] = last_target;
			default:         read_value = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_full       <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			ar_full       <= next_ar_full;
			s_axi_arready <= ~next_ar_full;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_addr <= '0;
		end else if (ar_take) begin
			ar_addr <= s_axi_araddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (read_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= read_value;
			s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Enable gates instruction acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_enable <= CTRL_ENABLE_RESET;
		end else if (ctrl_write) begin
			ctrl_enable <= w_data[CTRL_ENABLE_POS];
		end
	end

	// Clear is a one-cycle pulse, so the bit reads back as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clear_counts <= 1'b0;
		end else begin
			clear_counts <= ctrl_write & w_data[CTRL_CLEAR_POS];
		end
	end

	// Ready follows enable one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_ready <= 1'b0;
		end else begin
			instr_ready <= ctrl_enable;
		end
	end

	assign instr_fire   = instr_valid & instr_ready;
	assign branch_taken = instr_fire & dec_taken;

	// Status word: a branch wins over a flag load, which wins over software
	always_comb begin
		next_status = status_word;
		if (instr_fire) begin
			next_status = dec_status;
		end else if (flags_load) begin
			next_status = flags_in;
		end else if (status_write) begin
			if (w_strb[0]) begin
				next_status[7:0] = w_data[7:0];
			end
			if (w_strb[1]) begin
				next_status[STATUS_W-1] = w_data[STATUS_W-1];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_word <= STATUS_RESET;
		end else begin
			status_word <= next_status;
		end
	end

	// Redirect pulses: a taken branch flushes the sequentially fetched word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exec_done   <= 1'b0;
			exec_taken  <= 1'b0;
			fetch_flush <= 1'b0;
		end else begin
			exec_done   <= instr_fire;
			exec_taken  <= branch_taken;
			fetch_flush <= branch_taken;
		end
	end

	// Next fetch address holds until the next accepted instruction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_next <= '0;
		end else if (instr_fire) begin
			pc_next <= dec_taken ? branch_target : seq_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_target <= '0;
		end else if (branch_taken) begin
			last_target <= branch_target;
		end
	end

	// Counters: a count in the clearing cycle survives as one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			taken_count <= '0;
		end else if (clear_counts) begin
			taken_count <= {31'h0, branch_taken};
		end else if (branch_taken) begin
			taken_count <= taken_count + 32'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			exec_count <= '0;
		end else if (clear_counts) begin
			exec_count <= {31'h0, instr_fire};
		end else if (instr_fire) begin
			exec_count <= exec_count + 32'h1;
		end
	end

endmodule : conditional_branch_unit

// ---- dv/instr_feed_model.sv ----
module instr_feed_model
	import branch_unit_pkg::*;
(
	input  wire                  aclk,
	input  wire                  instr_ready,
	output logic                 instr_valid,
	output op_t                  instr_op,
	output logic [PC_W_DEF-1:0]  instr_pc,
	output logic [DISP_W-1:0]    instr_disp,
	output logic [LEN_W-1:0]     instr_len
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		instr_valid = 1'b0;
		instr_op = op_logic_false;
		instr_pc = '0;
		instr_disp = '0;
		instr_len = 2'h1;
	end

	task automatic offer(op_t op, logic [23:0] pc, logic [15:0] d, logic [1:0] len);
		instr_op <= op;
		instr_pc <= pc;
		instr_disp <= d;
		instr_len <= len;
		instr_valid <= 1;
		do @(posedge aclk); while (!instr_ready);
		instr_valid <= 0;
		// Released pc and displacement lines show the inverse so stale values cannot match
		instr_disp <= ~d;
		instr_pc <= ~pc;
	endtask : offer
endmodule : instr_feed_model

// ---- dv/conditional_branch_unit_asserts.sv ----
module conditional_branch_unit_asserts
	import branch_unit_pkg::*;
#(
	parameter int PC_W = PC_W_DEF
) (
	input wire                 aclk,
	input wire                 aresetn,
	input wire                 instr_valid,
	input wire                 instr_ready,
	input op_t                 instr_op,
	input wire [PC_W-1:0]      instr_pc,
	input wire [DISP_W-1:0]    instr_disp,
	input wire [LEN_W-1:0]     instr_len,
	input wire                 exec_done,
	input wire                 exec_taken,
	input wire                 fetch_flush,
	input wire [PC_W-1:0]      pc_next,
	input wire [STATUS_W-1:0]  status_word
);
	timeunit 1ns;
	timeprecision 100ps;

	wire take = instr_valid && instr_ready;
	wire lr = status_word[LOGIC_RESULT_POS];
	wire br = status_word[BINARY_RESULT_POS];
	wire save_op = instr_op == op_logic_true_save || instr_op == op_logic_false_save;
	wire bin_op = instr_op == op_binres_set || instr_op == op_binres_clear;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	false_jump_a: assert property (take && instr_op == op_logic_false
		|=> exec_done && exec_taken == !$past(lr)) else $error("logic false jump wrong");
	false_fall_a: assert property (take && instr_op == op_logic_false && lr
		|=> !exec_taken && status_word[3:0] == 4'h6) else $error("logic false fall wrong");
	save_jump_a: assert property (take && save_op
		|=> exec_taken == ($past(lr) ^ ($past(instr_op) == op_logic_false_save))
		&& status_word[3:0] == 4'h6) else $error("save jump wrong");
	save_copy_a: assert property (take && save_op
		|=> br == $past(lr)) else $error("save copy wrong");
	binres_jump_a: assert property (take && bin_op
		|=> exec_taken == ($past(br) ^ ($past(instr_op) == op_binres_clear)))
		else $error("binary result jump wrong");
	binres_keep_a: assert property (take && bin_op |=> status_word[8:4] == $past(status_word[8:4])
		&& status_word[3:0] == {2'b01, $past(lr), 1'b0}) else $error("binary result status wrong");
	range_keep_a: assert property (take && instr_op == op_range_error
		|=> exec_taken == $past(status_word[RANGE_EXCEED_POS])
		&& status_word == $past(status_word)) else $error("range jump wrong");
	sticky_clear_a: assert property (take && instr_op == op_sticky_range
		|=> exec_taken == $past(status_word[STICKY_RANGE_POS])
		&& status_word == ($past(status_word) & 9'h1ef)) else $error("sticky jump wrong");
	jump_target_a: assert property (exec_taken |-> fetch_flush
		&& pc_next == $past(instr_pc) + PC_W'($signed($past(instr_disp))))
		else $error("jump target wrong");
	seq_next_a: assert property (exec_done && !exec_taken
		|-> pc_next == $past(instr_pc) + PC_W'($past(instr_len))) else $error("sequential pc wrong");

	cover property (take && instr_op == op_logic_false_save);
	cover property (exec_taken && $past(instr_disp[15]));
	cover property (take && instr_op == op_sticky_range && status_word[STICKY_RANGE_POS]);
endmodule : conditional_branch_unit_asserts

bind conditional_branch_unit conditional_branch_unit_asserts #(
	.PC_W (PC_W)
) conditional_branch_unit_asserts_i (
	.aclk        (aclk),
	.aresetn     (aresetn),
	.instr_valid (instr_valid),
	.instr_ready (instr_ready),
	.instr_op    (instr_op),
	.instr_pc    (instr_pc),
	.instr_disp  (instr_disp),
	.instr_len   (instr_len),
	.exec_done   (exec_done),
	.exec_taken  (exec_taken),
	.fetch_flush (fetch_flush),
	.pc_next     (pc_next),
	.status_word (status_word)
);

// ---- dv/conditional_branch_unit_bench.sv ----
module conditional_branch_unit_bench import branch_unit_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic aclk = 0, aresetn = 0, flags_load = 0, s_axi_bready = 1, s_axi_rready = 1;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
	logic [3:0] s_axi_wstrb = 0;
	logic [8:0] flags_in = 0, status_word;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic instr_valid, instr_ready, exec_done, exec_taken, fetch_flush;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs, instr_len;
	op_t instr_op;
	logic [23:0] instr_pc, pc_next;
	logic [15:0] instr_disp;
	logic [8:0] pats [4] = '{9'h000, 9'h1ff, 9'h0aa, 9'h155};
	int miscompares = 0, compares = 0, n_taken = 0;
	logic [23:0] last_tgt = 24'h0;

	always #2.5 aclk = ~aclk;

	conditional_branch_unit conditional_branch_unit_i (.*);
	instr_feed_model instr_feed_model_i (.*);

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask : chk

	task automatic axi_write(logic [7:0] a, logic [31:0] d, logic [3:0] s, output logic [1:0] q);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		q = s_axi_bresp;
	endtask : axi_write

	task automatic axi_read(logic [7:0] a, output logic [31:0] d, output logic [1:0] q);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		q = s_axi_rresp;
	endtask : axi_read

	// Expected taken flag in bit 9, next status word below it
	function automatic logic [9:0] model(op_t op, logic [8:0] s);
		logic t;
		logic [8:0] n;
		n = s;
		case (op)
			op_logic_false, op_logic_false_save: t = !s[LOGIC_RESULT_POS];
			op_logic_true_save: t = s[LOGIC_RESULT_POS];
			op_binres_set: t = s[BINARY_RESULT_POS];
			op_binres_clear: t = !s[BINARY_RESULT_POS];
			op_range_error: t = s[RANGE_EXCEED_POS];
			op_sticky_range: t = s[STICKY_RANGE_POS];
			default: t = 1'b0;
		endcase
		if (op <= op_binres_clear) n[3:0] = {2'b01, s[LOGIC_RESULT_POS], 1'b0};
		if (op <= op_logic_false_save) n[LOGIC_RESULT_POS] = 1;
		if (op == op_logic_true_save || op == op_logic_false_save) n[8] = s[LOGIC_RESULT_POS];
		if (op == op_sticky_range) n[STICKY_RANGE_POS] = 0;
		return {t, n};
	endfunction : model

	task automatic run(op_t op, logic [8:0] f, logic [15:0] d, logic [1:0] len);
		logic [9:0] e;
		logic [23:0] pc;
		logic [23:0] tgt;
		e = model(op, f);
		pc = 24'h123456;
		tgt = pc + {{8{d[15]}}, d};
		@(posedge aclk);
		flags_load <= 1;
		flags_in <= f;
		@(posedge aclk);
		flags_load <= 0;
		instr_feed_model_i.offer(op, pc, d, len);
		@(negedge aclk);
		chk("exec_done", 1, exec_done);
		chk("exec_taken", e[9], exec_taken);
		chk("fetch_flush", e[9], fetch_flush);
		chk("pc_next", e[9] ? tgt : pc + 24'(len), pc_next);
		chk("status_word", e[8:0], status_word);
		n_taken += e[9];
		if (e[9]) last_tgt = tgt;
	endtask : run

	task automatic test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	initial begin
		#20000;
		miscompares++;
		$display("Error watchdog expected 0 seen 1");
		test_done;
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		repeat (2) @(posedge aclk);
		axi_read(ADDR_STATUS, r, rs);
		chk("status reset", 0, r);
		chk("status rresp", RESP_OKAY, rs);
		axi_read(ADDR_CONTROL, r, rs);
		chk("control reset", 1, r);
		axi_read(8'h14, r, rs);
		chk("unmapped rresp", RESP_SLVERR, rs);
		axi_write(8'h14, 0, 4'hf, rs);
		chk("unmapped bresp", RESP_SLVERR, rs);
		axi_write(ADDR_STATUS, 32'h1ff, 4'h3, rs);
		chk("status bresp", RESP_OKAY, rs);
		axi_write(ADDR_STATUS, 0, 4'h1, rs);
		axi_read(ADDR_STATUS, r, rs);
		chk("status strobe", 32'h100, r);
		axi_write(ADDR_CONTROL, 3, 4'h1, rs);
		$display("register test done");
		for (int k = 0; k < 32; k++)
			run(op_t'(k / 4), pats[k % 4], k[0] ? 16'h8000 : 16'h7fff, 2'(k % 3 + 1));
		$display("branch test done");
		axi_read(ADDR_TAKEN_COUNT, r, rs);
		chk("taken count", n_taken, r);
		axi_read(ADDR_EXEC_COUNT, r, rs);
		chk("exec count", 32, r);
		axi_read(ADDR_LAST_TARGET, r, rs);
		chk("last target", last_tgt, r);
		axi_write(ADDR_CONTROL, 3, 4'h1, rs);
		axi_read(ADDR_CONTROL, r, rs);
		chk("control clear", 1, r);
		axi_read(ADDR_TAKEN_COUNT, r, rs);
		chk("taken cleared", 0, r);
		$display("counter test done");
		axi_write(ADDR_CONTROL, 0, 4'h1, rs);
		repeat (2) @(posedge aclk);
		chk("instr_ready", 0, instr_ready);
		fork
			instr_feed_model_i.offer(op_logic_false, 24'h000010, 16'h0004, 2'h1);
		join_none
		repeat (4) @(posedge aclk);
		axi_read(ADDR_EXEC_COUNT, r, rs);
		chk("refused count", 0, r);
		axi_write(ADDR_CONTROL, 1, 4'h1, rs);
		repeat (4) @(posedge aclk);
		chk("instr_ready", 1, instr_ready);
		axi_read(ADDR_EXEC_COUNT, r, rs);
		chk("resumed count", 1, r);
		$display("enable test done");
		test_done;
	end
endmodule : conditional_branch_unit_bench
